// [hw/acc_defines.svh]
// register map, field positions and reset values of the channel and calibration registers
// assumes a byte-wide register port already decoded from the serial link
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// sizes
`define ACC_NUM_CH          7
`define ACC_NUM_CAL         4
`define ACC_COEF_BYTES      6

// addresses
`define ACC_ADDR_BGCAL      8'h10
`define ACC_ADDR_SCAL       8'h17
`define ACC_ADDR_CFG_BASE   8'h21
`define ACC_CFG_STRIDE      8'h02
`define ACC_ADDR_COEF_BASE  8'h30
`define ACC_COEF_STRIDE     8'h08
`define ACC_COEF_GAIN_IDX   3

// channel config fields
`define ACC_RATE_MSB        6
`define ACC_RATE_LSB        4
`define ACC_GAIN_MSB        3
`define ACC_GAIN_LSB        1
`define ACC_BUF_BIT         0
`define ACC_CFG_MASK        8'h7F
`define ACC_CFG_RESET       8'h70

// calibration fields
`define ACC_CAL_FIELD_MASK  8'h03
`define ACC_BGCAL_RESET     2'h0
`define ACC_SCAL_NORMAL     2'h0
`define ACC_SCAL_OFFSET     2'h1
`define ACC_SCAL_GAIN       2'h2
`define ACC_OFFSET_RESET    24'h000000
`define ACC_GAIN_COEF_RESET 24'h800000

`endif

// [hw/acc_pkg.sv]
// types shared by the channel and calibration register block
// assumes nothing beyond the defines header
`default_nettype none
package acc_pkg;
	typedef enum logic [1:0] {
		SCAL_NORMAL,
		SCAL_OFFSET_DET,
		SCAL_GAIN_DET
	} acc_scal_state_t;
	typedef logic [7:0] acc_byte_t;
endpackage
`default_nettype wire

// [hw/acc_chan_if.sv]
// carrier between the register bank and one channel decoder
// assumes one instance per channel, all on CLK_SYS
`default_nettype none
interface acc_chan_if;
	logic [7:0] cfg_byte;
	logic [2:0] rate_sel;
	logic [2:0] gain_sel;
	logic       fixed_gain_on;
	logic       buf_in_path;
	modport regs (output cfg_byte, input rate_sel, gain_sel, fixed_gain_on, buf_in_path);
	modport dec  (input cfg_byte, output rate_sel, gain_sel, fixed_gain_on, buf_in_path);
endinterface
`default_nettype wire

// [hw/acc_chan_decode.sv]
// turns one channel_config byte into registered analog controls
// assumes cfg_byte comes from a flip-flop on the same clock
`include "acc_defines.svh"
`default_nettype none
module acc_chan_decode (
	// clock and reset
	input  wire logic CLK_SYS,
	input  wire logic RST,
	// channel carrier
	acc_chan_if.dec   ch
);
	logic [2:0] rate_d, rate_q;
	logic [2:0] gain_d, gain_q;
	logic       fix_gain_d, fix_gain_q;
	logic       buf_d, buf_q;
	// reset image of the stored byte, so the outputs agree with it from the first edge
	localparam logic [7:0] cfg_rst = `ACC_CFG_RESET;

	// ===========================================================
	// decode
	always_comb begin
		rate_d = ch.cfg_byte[`ACC_RATE_MSB:`ACC_RATE_LSB]; // R1
		gain_d = ch.cfg_byte[`ACC_GAIN_MSB:`ACC_GAIN_LSB]; // R2
		fix_gain_d = gain_d[`ACC_GAIN_MSB-`ACC_GAIN_LSB]; // R3
		// high gains need the buffer, so the control bit loses there
		buf_d  = fix_gain_d | ~ch.cfg_byte[`ACC_BUF_BIT]; // R4 R5
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rate_q     <= cfg_rst[`ACC_RATE_MSB:`ACC_RATE_LSB];
			gain_q     <= cfg_rst[`ACC_GAIN_MSB:`ACC_GAIN_LSB];
			fix_gain_q <= cfg_rst[`ACC_GAIN_MSB];
			buf_q      <= cfg_rst[`ACC_GAIN_MSB] | ~cfg_rst[`ACC_BUF_BIT];
		end else begin
			rate_q     <= rate_d;
			gain_q     <= gain_d;
			fix_gain_q <= fix_gain_d;
			buf_q      <= buf_d;
		end
	end

	assign ch.rate_sel      = rate_q;
	assign ch.gain_sel      = gain_q;
	assign ch.fixed_gain_on = fix_gain_q;
	assign ch.buf_in_path   = buf_q;

	// ===========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	fixed_gain_follow_a: assert property ( // R3
		##1 ch.fixed_gain_on == ($past(ch.cfg_byte[`ACC_GAIN_MSB:`ACC_GAIN_LSB]) >= 3'h4))
		else $error("fixed gain stage disagrees with gain code");
	buffer_forced_a: assert property ( // R5
		ch.gain_sel >= 3'h4 |-> ch.buf_in_path)
		else $error("buffer left out at high gain");
	buffer_bit_a: assert property ( // R4
		$past(ch.cfg_byte[`ACC_GAIN_MSB]) == 1'b0 |-> ch.buf_in_path == !$past(ch.cfg_byte[0]))
		else $error("buffer path does not follow its control bit");
endmodule
`default_nettype wire

// [hw/acc_cal_regs.sv]
// channel configuration and calibration control registers
// assumes the serial link delivers decoded byte reads and writes on CLK_SYS
// How it works
// R1: rate field bits 6:4 picks one of eight output rates; default code 7.
// R2: gain field bits 3:1 gives gain two to the code; default unity.
// R3: fixed gain stage is on for gain codes 4 to 7 only.
// R4: bit 0 zero keeps the input buffer in path, one removes it.
// R5: gain of 16 or more keeps the buffer in whatever bit 0 says.
// R6: register 0x10 low two bits choose the background calibration scheme.
// R7: host writes 0x17 with 0 normal, 1 offset, 2 gain; never 3.
// R8: reading 0x17 returns the system calibration mode now in effect.
// R9: determination lasts one conversion then falls back to normal mode.
// R10: per channel 24-bit offset coefficient in three bytes, high byte first; the code holds four coefficient sets for seven channels.
// R11: per channel 24-bit gain coefficient, 1.23 format, high byte first; the code holds four coefficient sets for seven channels.
// R12: reserved bits read zero and ignore writes.
`include "acc_defines.svh"
`default_nettype none
module acc_cal_regs (
	// clock and reset
	input  wire logic                        CLK_SYS,
	input  wire logic                        RST,
	// register port
	input  wire logic [7:0]                  REG_ADDR,
	input  wire logic                        REG_WR,
	input  wire logic [7:0]                  REG_WDATA,
	input  wire logic                        REG_RD,
	output logic      [7:0]                  REG_RDATA,
	// converter
	input  wire logic                        CONV_DONE,
	// channel controls
	output logic      [3*`ACC_NUM_CH-1:0]    CH_RATE_SEL,
	output logic      [3*`ACC_NUM_CH-1:0]    CH_GAIN_SEL,
	output logic      [`ACC_NUM_CH-1:0]      CH_FIXED_GAIN_ON,
	output logic      [`ACC_NUM_CH-1:0]      CH_BUF_IN_PATH,
	// calibration controls
	output logic      [1:0]                  BG_CAL_SCHEME,
	output logic      [1:0]                  SYS_CAL_MODE,
	output logic      [24*`ACC_NUM_CAL-1:0]  SYS_CAL_OFFSET,
	output logic      [24*`ACC_NUM_CAL-1:0]  SYS_CAL_GAIN
);
	acc_pkg::acc_byte_t       cfg_d  [`ACC_NUM_CH];
	acc_pkg::acc_byte_t       cfg_q  [`ACC_NUM_CH];
	acc_pkg::acc_byte_t       coef_d [`ACC_NUM_CAL][`ACC_COEF_BYTES];
	acc_pkg::acc_byte_t       coef_q [`ACC_NUM_CAL][`ACC_COEF_BYTES];
	logic [1:0]               bg_d, bg_q;
	acc_pkg::acc_scal_state_t scal_d, scal_q;
	logic [7:0]               rdata_d, rdata_q;
	logic                     wr_scal;
	localparam logic [23:0]   offset_rst = `ACC_OFFSET_RESET;
	localparam logic [23:0]   gain_rst   = `ACC_GAIN_COEF_RESET;

	// ===========================================================
	// address decode
	function automatic logic cfg_hit(input logic [7:0] a, input int c);
		return a == 8'(`ACC_ADDR_CFG_BASE + `ACC_CFG_STRIDE * c);
	endfunction

	function automatic logic coef_hit(input logic [7:0] a, input int c, input int k);
		return a == 8'(`ACC_ADDR_COEF_BASE + `ACC_COEF_STRIDE * c + k);
	endfunction

	function automatic logic [1:0] scal_code(input acc_pkg::acc_scal_state_t s);
		case (s)
			acc_pkg::SCAL_OFFSET_DET: return `ACC_SCAL_OFFSET;
			acc_pkg::SCAL_GAIN_DET:   return `ACC_SCAL_GAIN;
			default:                  return `ACC_SCAL_NORMAL;
		endcase
	endfunction

	assign wr_scal = REG_WR && REG_ADDR == `ACC_ADDR_SCAL;

	// ===========================================================
	// storage next values
	always_comb begin
		for (int c = 0; c < `ACC_NUM_CH; c++) begin
			cfg_d[c] = cfg_q[c];
			if (REG_WR && cfg_hit(REG_ADDR, c)) begin
				cfg_d[c] = REG_WDATA & `ACC_CFG_MASK; // R12
			end
		end
		for (int c = 0; c < `ACC_NUM_CAL; c++) begin
			for (int k = 0; k < `ACC_COEF_BYTES; k++) begin
				coef_d[c][k] = coef_q[c][k];
				if (REG_WR && coef_hit(REG_ADDR, c, k)) begin
					coef_d[c][k] = REG_WDATA; // R10 R11
				end
			end
		end
		bg_d = bg_q;
		if (REG_WR && REG_ADDR == `ACC_ADDR_BGCAL) begin
			bg_d = REG_WDATA[1:0]; // R6 R12
		end
	end

	// ===========================================================
	// system calibration mode
	always_comb begin
		scal_d = scal_q;
		case (scal_q)
			acc_pkg::SCAL_NORMAL: begin
				scal_d = acc_pkg::SCAL_NORMAL;
			end
			acc_pkg::SCAL_OFFSET_DET, acc_pkg::SCAL_GAIN_DET: begin
				if (CONV_DONE) begin
					scal_d = acc_pkg::SCAL_NORMAL; // R9
				end
			end
			default: begin
				scal_d = acc_pkg::SCAL_NORMAL;
			end
		endcase
		// a write landing on the closing conversion still wins
		if (wr_scal) begin
			case (REG_WDATA[1:0])
				`ACC_SCAL_NORMAL: begin
					scal_d = acc_pkg::SCAL_NORMAL; // R7
				end
				`ACC_SCAL_OFFSET: begin
					scal_d = acc_pkg::SCAL_OFFSET_DET; // R7
				end
				`ACC_SCAL_GAIN: begin
					scal_d = acc_pkg::SCAL_GAIN_DET; // R7
				end
				default: begin
					scal_d = scal_d; // R7
				end
			endcase
		end
	end

	// ===========================================================
	// read data, held until the next read
	always_comb begin
		rdata_d = rdata_q;
		if (REG_RD) begin
			rdata_d = 8'h00; // R12
			if (REG_ADDR == `ACC_ADDR_BGCAL) begin
				rdata_d = {6'h00, bg_q};
			end
			if (REG_ADDR == `ACC_ADDR_SCAL) begin
				rdata_d = {6'h00, scal_code(scal_q)}; // R8
			end
			for (int c = 0; c < `ACC_NUM_CH; c++) begin
				if (cfg_hit(REG_ADDR, c)) begin
					rdata_d = cfg_q[c];
				end
			end
			for (int c = 0; c < `ACC_NUM_CAL; c++) begin
				for (int k = 0; k < `ACC_COEF_BYTES; k++) begin
					if (coef_hit(REG_ADDR, c, k)) begin
						rdata_d = coef_q[c][k];
					end
				end
			end
		end
	end

	// ===========================================================
	// registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int c = 0; c < `ACC_NUM_CH; c++) begin
				cfg_q[c] <= `ACC_CFG_RESET; // R1 R2 R4
			end
			for (int c = 0; c < `ACC_NUM_CAL; c++) begin
				coef_q[c][0] <= offset_rst[23:16];
				coef_q[c][1] <= offset_rst[15:8];
				coef_q[c][2] <= offset_rst[7:0];
				coef_q[c][3] <= gain_rst[23:16];
				coef_q[c][4] <= gain_rst[15:8];
				coef_q[c][5] <= gain_rst[7:0];
			end
			bg_q    <= `ACC_BGCAL_RESET;
			scal_q  <= acc_pkg::SCAL_NORMAL;
			rdata_q <= 8'h00;
		end else begin
			cfg_q   <= cfg_d;
			coef_q  <= coef_d;
			bg_q    <= bg_d;
			scal_q  <= scal_d;
			rdata_q <= rdata_d;
		end
	end

	// ===========================================================
	// channel decoders
	generate
		for (genvar c = 0; c < `ACC_NUM_CH; c++) begin : g_ch
			acc_chan_if chan ();
			assign chan.cfg_byte = cfg_q[c];
			acc_chan_decode u_dec (
				.CLK_SYS (CLK_SYS),
				.RST     (RST),
				.ch      (chan)
			);
			assign CH_RATE_SEL[3*c +: 3]  = chan.rate_sel;
			assign CH_GAIN_SEL[3*c +: 3]  = chan.gain_sel;
			assign CH_FIXED_GAIN_ON[c]    = chan.fixed_gain_on;
			assign CH_BUF_IN_PATH[c]      = chan.buf_in_path;
		end
		for (genvar c = 0; c < `ACC_NUM_CAL; c++) begin : g_cal
			assign SYS_CAL_OFFSET[24*c +: 24] = {coef_q[c][0], coef_q[c][1], coef_q[c][2]};
			assign SYS_CAL_GAIN[24*c +: 24]   = {coef_q[c][3], coef_q[c][4], coef_q[c][5]};
		end
	endgenerate

	assign BG_CAL_SCHEME = bg_q;
	assign SYS_CAL_MODE  = scal_code(scal_q);
	assign REG_RDATA     = rdata_q;

	// ===========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence cfg0_write;
		REG_WR && REG_ADDR == `ACC_ADDR_CFG_BASE;
	endsequence
	sequence det_running;
		SYS_CAL_MODE != 2'h0 && !wr_scal;
	endsequence

	rate_field_a: assert property ( // R1
		cfg0_write |-> ##2 CH_RATE_SEL[2:0] == $past(REG_WDATA[6:4], 2))
		else $error("rate select did not follow the write");
	gain_field_a: assert property ( // R2
		cfg0_write |-> ##2 CH_GAIN_SEL[2:0] == $past(REG_WDATA[3:1], 2))
		else $error("gain select did not follow the write");
	bg_scheme_a: assert property ( // R6
		REG_WR && REG_ADDR == 8'h10 |=> BG_CAL_SCHEME == $past(REG_WDATA[1:0]))
		else $error("background scheme not taken");
	scal_start_a: assert property ( // R7
		wr_scal && REG_WDATA[1:0] != 2'h3 |=> SYS_CAL_MODE == $past(REG_WDATA[1:0]))
		else $error("calibration mode not started");
	scal_reserved_a: assert property ( // R7
		wr_scal && REG_WDATA[1:0] == 2'h3 && !CONV_DONE |=> $stable(SYS_CAL_MODE))
		else $error("reserved calibration code acted on");
	scal_return_a: assert property ( // R9
		det_running ##0 CONV_DONE |=> SYS_CAL_MODE == 2'h0)
		else $error("calibration mode did not end after one conversion");
	scal_hold_a: assert property ( // R9
		det_running ##0 !CONV_DONE |=> $stable(SYS_CAL_MODE))
		else $error("calibration mode ended early");
	scal_read_a: assert property ( // R8
		REG_RD && REG_ADDR == 8'h17 |=> REG_RDATA == {6'h00, $past(SYS_CAL_MODE)})
		else $error("calibration read does not show the mode");
	reserved_read_a: assert property ( // R12
		REG_RD && (REG_ADDR == 8'h10 || REG_ADDR == 8'h17) |=> REG_RDATA[7:2] == 6'h00)
		else $error("reserved bits read non-zero");
	offset_byte_a: assert property ( // R10
		REG_WR && REG_ADDR == 8'h30 |=> SYS_CAL_OFFSET[23:16] == $past(REG_WDATA))
		else $error("offset high byte not stored");
	gain_byte_a: assert property ( // R11
		REG_WR && REG_ADDR == 8'h35 |=> SYS_CAL_GAIN[7:0] == $past(REG_WDATA))
		else $error("gain low byte not stored");
endmodule
`default_nettype wire

// [verif/acc_host_model.sv]
// host side of the register port: byte write and read tasks
// assumes strobes and read data are taken on the rising edge of clk
`default_nettype none
module acc_host_model (
	// clock
	input  wire logic       clk,
	// register port
	output var  logic [7:0] addr,
	output var  logic       wr,
	output var  logic [7:0] wdata,
	output var  logic       rd,
	input  wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		addr  = 8'h00;
		wr    = 1'b0;
		wdata = 8'h00;
		rd    = 1'b0;
	end
	// released lines show the inverse so a stale value never passes for a live one
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk);
		#1;
		addr  = a;
		wdata = d;
		wr    = w;
		rd    = !w;
		@(posedge clk);
		#1;
		wr    = 1'b0;
		rd    = 1'b0;
		addr  = ~a;
		wdata = ~d;
	endtask
	// code 3 to the calibration control only goes out when a scenario asks for it
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		put(a, d, 1'b1);
	endtask
	// read data stands from the taking edge on
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		put(a, 8'h00, 1'b0);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// [verif/acc_cal_regs_tb.sv]
// self-checking bench for the channel and calibration register block
// assumes the host model drives the register port and this bench the conversion pulse
`include "acc_defines.svh"
`default_nettype none
module acc_cal_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                       clk_sys = 1'b0;
	logic                       rst = 1'b1;
	logic                       conv_done = 1'b0;
	logic [7:0]                 reg_addr, reg_wdata, reg_rdata, rdv, d;
	logic                       reg_wr, reg_rd;
	logic [3*`ACC_NUM_CH-1:0]   ch_rate, ch_gain;
	logic [`ACC_NUM_CH-1:0]     ch_fix, ch_buf;
	logic [1:0]                 bg_cal, sys_cal;
	logic [24*`ACC_NUM_CAL-1:0] cal_off, cal_gain;
	int                         err_count = 0;
	int                         n_checks = 0;
	int                         c;
	always #12.5 clk_sys = ~clk_sys;
	acc_host_model i_host (.clk(clk_sys), .addr(reg_addr), .wr(reg_wr), .wdata(reg_wdata),
		.rd(reg_rd), .rdata(reg_rdata));
	acc_cal_regs i_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CONV_DONE(conv_done),
		.CH_RATE_SEL(ch_rate), .CH_GAIN_SEL(ch_gain), .CH_FIXED_GAIN_ON(ch_fix),
		.CH_BUF_IN_PATH(ch_buf), .BG_CAL_SCHEME(bg_cal), .SYS_CAL_MODE(sys_cal),
		.SYS_CAL_OFFSET(cal_off), .SYS_CAL_GAIN(cal_gain));
	// ==========================================
	// checking and closing
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_host.read(a, rdv);
		chk("read data", {16'h0000, exp}, {16'h0000, rdv});
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// ==========================================
	// scenarios
	initial begin
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chk("rate sel", 24'h1FFFFF, {3'b000, ch_rate});
		chk("gain sel", 24'h000000, {3'b000, ch_gain});
		chk("buffer", 24'h00007F, {17'h00000, ch_buf});
		chk("fixed gain", 24'h000000, {17'h00000, ch_fix});
		chk("bg scheme", 24'h000000, {22'h0, bg_cal});
		chk("cal mode", 24'h000000, {22'h0, sys_cal});
		chk("offset coef", 24'h000000, cal_off[23:0]);
		chk("gain coef", 24'h800000, cal_gain[95:72]);
		for (c = 0; c < `ACC_NUM_CH; c++) begin
			rdchk(8'(`ACC_ADDR_CFG_BASE + `ACC_CFG_STRIDE * c), 8'h70);
		end
		rdchk(8'h10, 8'h00);
		rdchk(8'h17, 8'h00);
		rdchk(8'h33, 8'h80);
		// every gain and rate code, reserved bit set, buffer bit asking for removal
		for (int g = 0; g < 8; g++) begin
			c = g % `ACC_NUM_CH;
			d = {1'b1, 3'(g), 3'(g), 1'b1};
			i_host.write(8'(`ACC_ADDR_CFG_BASE + `ACC_CFG_STRIDE * c), d);
			tick();
			chk("rate sel", 24'(g), {21'h0, ch_rate[3*c +: 3]});
			chk("gain sel", 24'(g), {21'h0, ch_gain[3*c +: 3]});
			chk("fixed gain", {23'h0, g >= 4}, {23'h0, ch_fix[c]});
			chk("buffer", {23'h0, g >= 4}, {23'h0, ch_buf[c]});
			rdchk(8'(`ACC_ADDR_CFG_BASE + `ACC_CFG_STRIDE * c), d & 8'h7F);
		end
		for (int k = 0; k < 4; k++) begin
			i_host.write(8'h10, {6'h3F, 2'(k)});
			chk("bg scheme", 24'(k), {22'h0, bg_cal});
			rdchk(8'h10, 8'(k));
		end
		// each determination mode, a refused code 3, then one conversion ends it
		for (int m = 1; m < 3; m++) begin
			i_host.write(8'h17, {6'h3F, 2'(m)});
			chk("cal mode", 24'(m), {22'h0, sys_cal});
			i_host.write(8'h17, 8'h03);
			chk("cal mode", 24'(m), {22'h0, sys_cal});
			rdchk(8'h17, 8'(m));
			tick();
			conv_done = 1'b1;
			tick();
			conv_done = 1'b0;
			chk("cal mode", 24'h0, {22'h0, sys_cal});
			rdchk(8'h17, 8'h00);
		end
		i_host.write(8'h17, 8'h01);
		i_host.write(8'h17, 8'h00);
		chk("cal mode", 24'h0, {22'h0, sys_cal});
		// a start landing on a conversion end still takes effect
		fork
			i_host.write(8'h17, 8'h02);
			begin
				tick();
				conv_done = 1'b1;
				tick();
				conv_done = 1'b0;
			end
		join
		chk("cal mode", 24'h2, {22'h0, sys_cal});
		tick();
		conv_done = 1'b1;
		tick();
		conv_done = 1'b0;
		chk("cal mode", 24'h0, {22'h0, sys_cal});
		for (int i = 0; i < 6; i++) begin
			i_host.write(8'(8'h48 + i), 8'(8'h12 + 8'h22 * i));
		end
		chk("offset coef", 24'h123456, cal_off[95:72]);
		chk("gain coef", 24'h789ABC, cal_gain[95:72]);
		chk("gain coef", 24'h800000, cal_gain[23:0]);
		rdchk(8'h4B, 8'h78);
		i_host.write(8'h30, 8'hA5);
		i_host.write(8'h35, 8'h5A);
		chk("offset coef", 24'hA50000, cal_off[23:0]);
		chk("gain coef", 24'h80005A, cal_gain[23:0]);
		// a hole between channel registers takes nothing
		i_host.write(8'h22, 8'hFF);
		rdchk(8'h22, 8'h00);
		close_out();
	end
	initial begin
		#500000;
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
